// [pwm_fault_map.svh]
// Register offsets, field positions and reset values
// Assumes byte addressing on a 32-bit AXI4-Lite bus
`ifndef PWM_FAULT_MAP_SVH
`define PWM_FAULT_MAP_SVH

`define OFS_TIMEBASE 8'h00
`define OFS_PERIOD 8'h04
`define OFS_TB_CTRL 8'h08
`define OFS_FAULT_A_CTRL 8'h0C
`define OFS_FAULT_B_CTRL 8'h10
`define OFS_PORT 8'h14
`define OFS_TRIS 8'h18
`define OFS_IRQ_STATUS 8'h1C
`define OFS_IRQ_ENABLE 8'h20
`define OFS_IRQ_CLEAR 8'h24
`define OFS_IRQ_PRIO 8'h28

`define TB_CNT_MSB 14
`define TB_DIR_BIT 15
`define TB_CTRL_RUN_BIT 0
`define TB_CTRL_UPDN_BIT 1
`define PIN_A_BIT 0
`define PIN_B_BIT 1

`define TB_RST 15'h0000
`define PERIOD_RST 15'h7FFF
`define CTRL_RST 2'h0
`define PIN_BITS_RST 2'h0

`endif

// [pwm_fault_pkg.sv]
// Types shared by the time base and fault input design
// Assumes nothing beyond the map header
package pwm_fault_pkg;
  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2
  } axi_resp_t;
  typedef logic [7:0] reg_addr_t;
  typedef logic [15:0] reg_word_t;
endpackage : pwm_fault_pkg

// [timebase_counter.sv]
// Time base count with software load and optional up/down counting
// Assumes load has priority over counting in the same cycle
`timescale 1ns/10ps
`include "pwm_fault_map.svh"
module timebase_counter #(
  parameter int W = 15
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  input wire logic run,
  input wire logic updown,
  input wire logic [W-1:0] period,
  output logic [W-1:0] count_q,
  output logic down_q
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= `TB_RST; // [R1]
      down_q <= 1'b0;
    end else if (load) begin
      count_q <= load_value; // [R1]
    end else if (run) begin
      if (!updown) begin
        down_q <= 1'b0;
        count_q <= (count_q >= period) ? '0 : W'(count_q + 1'b1);
      end else if (down_q) begin
        if (count_q == '0) begin
          down_q <= 1'b0;
        end else begin
          count_q <= W'(count_q - 1'b1);
        end
      end else if (count_q >= period) begin
        down_q <= 1'b1;
      end else begin
        count_q <= W'(count_q + 1'b1);
      end
    end
  end
endmodule : timebase_counter

// [fault_channel.sv]
// One active-low fault pin: sticky flag, output override, pin sharing
// Assumes the pin level is synchronous to aclk
`timescale 1ns/10ps
module fault_channel #(
  parameter int NUM_OUT = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_level,
  input wire logic [NUM_OUT-1:0] control,
  input wire logic port_latch,
  input wire logic tris_out,
  input wire logic flag_clear,
  output logic pin_out,
  output logic pin_oe,
  output logic active,
  output logic flag_q,
  output logic [NUM_OUT-1:0] override_q
);
  logic used;
  assign used = |control; // [R6]
  assign active = used && !pin_level; // [R2] [R7]
  // Pin free for general use only while no enable bit is set
  assign pin_oe = !used && tris_out; // [R4]
  assign pin_out = port_latch;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (active) begin
      flag_q <= 1'b1; // [R8]
    end else if (flag_clear) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      override_q <= '0;
    end else begin
      override_q <= active ? control : '0; // [R6]
    end
  end
endmodule : fault_channel

// [pwm_timebase_fault_inputs.sv]
// PWM time base count register and two fault input pins behind AXI4-Lite
// Assumes one clock, synchronous fault pins and one outstanding access
//
// Summary of operation
// R1: Fifteen-bit time base count, read/write, reset zero
// R2: Fault inputs assert on a low level
// R3: Port register reads fault pin level
// R4: Unused fault pin serves as general I/O
// R5: Each pin has own flag, enable, priority, vector; this block has no vector output, only flag, enable and priority
// R6: All enables clear: pin has no effect
// R7: All enables clear: no fault interrupt
// R8: Enabled low pin sets sticky flag until cleared
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "pwm_fault_map.svh"
module pwm_timebase_fault_inputs #(
  parameter int NUM_OUT = 4,
  parameter int PRIO_W = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fault_input_a,
  output logic fault_input_a_out,
  output logic fault_input_a_oe,
  input wire logic fault_input_b,
  output logic fault_input_b_out,
  output logic fault_input_b_oe,
  output logic [NUM_OUT-1:0] fault_override,
  output logic [`TB_CNT_MSB:0] pwm_timebase_count,
  output logic timebase_count_direction,
  output logic fault_a_irq,
  output logic fault_b_irq,
  output logic [PRIO_W-1:0] fault_a_priority,
  output logic [PRIO_W-1:0] fault_b_priority,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic pwm_fault_pkg::reg_word_t merge(
    input pwm_fault_pkg::reg_word_t old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    pwm_fault_pkg::reg_word_t res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge

  function automatic logic mapped(input pwm_fault_pkg::reg_addr_t a);
    case (a)
      `OFS_TIMEBASE, `OFS_PERIOD, `OFS_TB_CTRL, `OFS_FAULT_A_CTRL,
      `OFS_FAULT_B_CTRL, `OFS_PORT, `OFS_TRIS, `OFS_IRQ_STATUS,
      `OFS_IRQ_ENABLE, `OFS_IRQ_CLEAR, `OFS_IRQ_PRIO: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam int TBW = `TB_CNT_MSB + 1;
  logic aw_have_q;
  logic w_have_q;
  pwm_fault_pkg::reg_addr_t aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  pwm_fault_pkg::reg_addr_t wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic ar_take;
  logic [31:0] rd_data_d;
  logic [TBW-1:0] period_q;
  logic [1:0] tb_ctrl_q;
  logic [NUM_OUT-1:0] fault_a_control_q;
  logic [NUM_OUT-1:0] fault_b_control_q;
  logic [1:0] port_latch_q;
  logic [1:0] tris_q;
  logic [1:0] irq_en_q;
  logic [2*PRIO_W-1:0] prio_q;
  logic [1:0] status;
  logic [1:0] clr;
  logic tb_load;
  logic act_a;
  logic act_b;
  logic [NUM_OUT-1:0] ovr_a;
  logic [NUM_OUT-1:0] ovr_b;
  pwm_fault_pkg::reg_word_t wr_word;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_fire = (aw_have_q || aw_take) && (w_have_q || w_take);
  assign wr_addr = aw_have_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_have_q ? w_data_q : s_axi_wdata;
  assign wr_strb = w_have_q ? w_strb_q : s_axi_wstrb;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end else if (aw_take) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end else if (w_take) begin
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pwm_fault_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(wr_addr) ? pwm_fault_pkg::RESP_OKAY : pwm_fault_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  assign wr_word = merge(16'h0000, wr_data, wr_strb);
  assign tb_load = wr_fire && (wr_addr == `OFS_TIMEBASE) && (|wr_strb[1:0]);
  assign clr[`PIN_A_BIT] = wr_fire && (wr_addr == `OFS_IRQ_CLEAR) && wr_strb[0] && wr_data[`PIN_A_BIT];
  assign clr[`PIN_B_BIT] = wr_fire && (wr_addr == `OFS_IRQ_CLEAR) && wr_strb[0] && wr_data[`PIN_B_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_q <= `PERIOD_RST;
      tb_ctrl_q <= `CTRL_RST;
    end else if (wr_fire && wr_addr == `OFS_PERIOD) begin
      period_q <= TBW'(merge({1'b0, period_q}, wr_data, wr_strb));
    end else if (wr_fire && wr_addr == `OFS_TB_CTRL && wr_strb[0]) begin
      tb_ctrl_q <= wr_data[1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_a_control_q <= '0;
      fault_b_control_q <= '0;
    end else if (wr_fire && wr_strb[0] && wr_addr == `OFS_FAULT_A_CTRL) begin
      fault_a_control_q <= wr_data[NUM_OUT-1:0];
    end else if (wr_fire && wr_strb[0] && wr_addr == `OFS_FAULT_B_CTRL) begin
      fault_b_control_q <= wr_data[NUM_OUT-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_latch_q <= `PIN_BITS_RST;
      tris_q <= `PIN_BITS_RST;
    end else if (wr_fire && wr_strb[0] && wr_addr == `OFS_PORT) begin
      port_latch_q <= wr_data[1:0]; // [R4]
    end else if (wr_fire && wr_strb[0] && wr_addr == `OFS_TRIS) begin
      tris_q <= wr_data[1:0]; // [R4]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_q <= `PIN_BITS_RST;
      prio_q <= '0;
    end else if (wr_fire && wr_strb[0] && wr_addr == `OFS_IRQ_ENABLE) begin
      irq_en_q <= wr_data[1:0]; // [R5]
    end else if (wr_fire && wr_strb[0] && wr_addr == `OFS_IRQ_PRIO) begin
      prio_q <= wr_data[2*PRIO_W-1:0]; // [R5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time base and fault channels

  timebase_counter #(.W(TBW)) u_timebase (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(tb_load),
    .load_value(wr_word[`TB_CNT_MSB:0]),
    .run(tb_ctrl_q[`TB_CTRL_RUN_BIT]),
    .updown(tb_ctrl_q[`TB_CTRL_UPDN_BIT]),
    .period(period_q),
    .count_q(pwm_timebase_count),
    .down_q(timebase_count_direction)
  );

  fault_channel #(.NUM_OUT(NUM_OUT)) u_fault_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_level(fault_input_a),
    .control(fault_a_control_q),
    .port_latch(port_latch_q[`PIN_A_BIT]),
    .tris_out(tris_q[`PIN_A_BIT]),
    .flag_clear(clr[`PIN_A_BIT]),
    .pin_out(fault_input_a_out),
    .pin_oe(fault_input_a_oe),
    .active(act_a),
    .flag_q(status[`PIN_A_BIT]),
    .override_q(ovr_a)
  );

  fault_channel #(.NUM_OUT(NUM_OUT)) u_fault_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_level(fault_input_b),
    .control(fault_b_control_q),
    .port_latch(port_latch_q[`PIN_B_BIT]),
    .tris_out(tris_q[`PIN_B_BIT]),
    .flag_clear(clr[`PIN_B_BIT]),
    .pin_out(fault_input_b_out),
    .pin_oe(fault_input_b_oe),
    .active(act_b),
    .flag_q(status[`PIN_B_BIT]),
    .override_q(ovr_b)
  );

  assign fault_override = ovr_a | ovr_b; // [R6]

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  assign fault_a_irq = status[`PIN_A_BIT] && irq_en_q[`PIN_A_BIT]; // [R5]
  assign fault_b_irq = status[`PIN_B_BIT] && irq_en_q[`PIN_B_BIT]; // [R5]
  assign fault_a_priority = prio_q[PRIO_W-1:0]; // [R5]
  assign fault_b_priority = prio_q[2*PRIO_W-1:PRIO_W]; // [R5]
  assign irq = fault_a_irq || fault_b_irq;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_data_d = '0;
    case (s_axi_araddr)
      `OFS_TIMEBASE: begin
        rd_data_d[`TB_DIR_BIT] = timebase_count_direction;
        rd_data_d[`TB_CNT_MSB:0] = pwm_timebase_count; // [R1]
      end
      `OFS_PERIOD: rd_data_d[`TB_CNT_MSB:0] = period_q;
      `OFS_TB_CTRL: rd_data_d[1:0] = tb_ctrl_q;
      `OFS_FAULT_A_CTRL: rd_data_d[NUM_OUT-1:0] = fault_a_control_q;
      `OFS_FAULT_B_CTRL: rd_data_d[NUM_OUT-1:0] = fault_b_control_q;
      `OFS_PORT: rd_data_d[1:0] = {fault_input_b, fault_input_a}; // [R3]
      `OFS_TRIS: rd_data_d[1:0] = tris_q;
      `OFS_IRQ_STATUS: rd_data_d[1:0] = status;
      `OFS_IRQ_ENABLE: rd_data_d[1:0] = irq_en_q;
      `OFS_IRQ_PRIO: rd_data_d[2*PRIO_W-1:0] = prio_q;
      default: rd_data_d = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pwm_fault_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data_d;
      s_axi_rresp <= mapped(s_axi_araddr) ? pwm_fault_pkg::RESP_OKAY : pwm_fault_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_tb_load;
    @(posedge aclk) disable iff (!aresetn)
    tb_load |=> pwm_timebase_count == TBW'($past(wr_word));
  endproperty
  a_tb_load: assert property (p_tb_load) else $error("Time base write not stored"); // [R1]

  property p_tb_reset;
    @(posedge aclk)
    !aresetn |=> pwm_timebase_count == '0 && !timebase_count_direction;
  endproperty
  a_tb_reset: assert property (p_tb_reset) else $error("Time base not cleared by reset"); // [R1]

  property p_low_sets_flag;
    @(posedge aclk) disable iff (!aresetn)
    (fault_a_control_q != '0) && !fault_input_a |=> status[`PIN_A_BIT] [*1] ##0 fault_a_irq == irq_en_q[`PIN_A_BIT];
  endproperty
  a_low_sets_flag: assert property (p_low_sets_flag) else $error("Low enabled pin did not set flag"); // [R2] [R8]

  property p_flag_sticky;
    @(posedge aclk) disable iff (!aresetn)
    status[`PIN_B_BIT] && !clr[`PIN_B_BIT] |=> status[`PIN_B_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("Fault flag dropped without clear"); // [R8]

  property p_disabled_no_irq;
    @(posedge aclk) disable iff (!aresetn)
    (fault_a_control_q == '0) && !status[`PIN_A_BIT] |=> !status[`PIN_A_BIT] && !fault_a_irq;
  endproperty
  a_disabled_no_irq: assert property (p_disabled_no_irq) else $error("Disabled pin raised interrupt"); // [R7]

  property p_port_read;
    @(posedge aclk) disable iff (!aresetn)
    ar_take && s_axi_araddr == `OFS_PORT |=>
      s_axi_rvalid && s_axi_rdata[1:0] == {$past(fault_input_b), $past(fault_input_a)};
  endproperty
  a_port_read: assert property (p_port_read) else $error("Port read does not show pin level"); // [R3]

  property p_pin_release;
    @(posedge aclk) disable iff (!aresetn)
    (fault_b_control_q != '0) |-> !fault_input_b_oe;
  endproperty
  a_pin_release: assert property (p_pin_release) else $error("Fault pin driven while in use"); // [R4]

  property p_no_effect;
    @(posedge aclk) disable iff (!aresetn)
    (fault_a_control_q == '0) && (fault_b_control_q == '0) |=> fault_override == '0;
  endproperty
  a_no_effect: assert property (p_no_effect) else $error("Disabled pins affect outputs"); // [R6]

  property p_write_resp;
    @(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid ##0 (s_axi_bresp == pwm_fault_pkg::RESP_OKAY) == mapped($past(wr_addr));
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("Write response missing or wrong"); // Local design decision: AXI4-Lite slave port
endmodule : pwm_timebase_fault_inputs

// [fault_sources.sv]
// Model of the external fault sources on the two fault pins
// Assumes two open-drain sources per pin, a pull-up, and device drive by enable
`timescale 1ns/10ps
module fault_sources (
  input wire logic [1:0] pull_a,
  input wire logic [1:0] pull_b,
  input wire logic a_out,
  input wire logic a_oe,
  input wire logic b_out,
  input wire logic b_oe,
  output logic pin_a,
  output logic pin_b
);
  ////////////////////////////////////////
  // Any low source wins, else device drive, else pull-up
  assign pin_a = (|pull_a) ? 1'b0 : (a_oe ? a_out : 1'b1);
  assign pin_b = (|pull_b) ? 1'b0 : (b_oe ? b_out : 1'b1);
endmodule : fault_sources

// [pwm_timebase_fault_inputs_bench.sv]
// Self-checking bench for the time base and fault input block
// Assumes default parameters, AXI4-Lite master here, sources in fault_sources
`timescale 1ns/10ps
module pwm_timebase_fault_inputs_bench;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic [1:0] br;
    logic [31:0] q;
    logic [1:0] rr;
  } row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [1:0] pull_a = 2'h0;
  logic [1:0] pull_b = 2'h0;
  logic pin_a, pin_b, a_out, a_oe, b_out, b_oe, tb_dir, a_irq, b_irq, irq;
  logic [3:0] override;
  logic [14:0] tb_count;
  logic [2:0] a_prio, b_prio;
  int comparisons = 0;
  int failures = 0;
  row_t rows [13] = '{
    '{8'h00, 32'h0000_1234, 2'h0, 32'h0000_1234, 2'h0},
    '{8'h00, 32'hFFFF_FFFF, 2'h0, 32'h0000_7FFF, 2'h0},
    '{8'h04, 32'h0000_0100, 2'h0, 32'h0000_0100, 2'h0},
    '{8'h08, 32'hFFFF_FFFF, 2'h0, 32'h0000_0003, 2'h0},
    '{8'h0C, 32'h0000_00FF, 2'h0, 32'h0000_000F, 2'h0},
    '{8'h0C, 32'h0, 2'h0, 32'h0, 2'h0},
    '{8'h10, 32'h0000_000A, 2'h0, 32'h0000_000A, 2'h0},
    '{8'h10, 32'h0, 2'h0, 32'h0, 2'h0},
    '{8'h20, 32'h0000_00FF, 2'h0, 32'h0000_0003, 2'h0},
    '{8'h28, 32'h0000_00FF, 2'h0, 32'h0000_003F, 2'h0},
    '{8'h24, 32'h0000_0003, 2'h0, 32'h0, 2'h0},
    '{8'h1C, 32'h0000_0003, 2'h0, 32'h0, 2'h0},
    '{8'h40, 32'h0000_0001, 2'h2, 32'h0, 2'h2}};

  always #5 aclk = ~aclk;

  ////////////////////////////////////////
  pwm_timebase_fault_inputs u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fault_input_a(pin_a), .fault_input_a_out(a_out), .fault_input_a_oe(a_oe),
    .fault_input_b(pin_b), .fault_input_b_out(b_out), .fault_input_b_oe(b_oe),
    .fault_override(override), .pwm_timebase_count(tb_count), .timebase_count_direction(tb_dir),
    .fault_a_irq(a_irq), .fault_b_irq(b_irq), .fault_a_priority(a_prio),
    .fault_b_priority(b_prio), .irq(irq));

  fault_sources u_src (
    .pull_a(pull_a), .pull_b(pull_b), .a_out(a_out), .a_oe(a_oe),
    .b_out(b_out), .b_oe(b_oe), .pin_a(pin_a), .pin_b(pin_b));

  ////////////////////////////////////////
  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk32

  task automatic chk1(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic stall_out;
    failures++;
    $display("BAD handshake expected answer seen none");
    finish_test();
  endtask : stall_out

  task automatic wait_dir(input logic lvl);
    int n;
    n = 0;
    while (tb_dir !== lvl && n < 40) begin
      @(posedge aclk);
      n++;
    end
    if (tb_dir !== lvl) stall_out();
  endtask : wait_dir

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] br);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got && n < 40) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        chk32("bresp", {30'h0, br}, {30'h0, bresp});
        got = 1'b1;
      end
    end
    bready <= 1'b0;
    if (!got) stall_out();
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] q, input logic [1:0] rr);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got && n < 40) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        chk32("rdata", q, rdata);
        chk32("rresp", {30'h0, rr}, {30'h0, rresp});
        got = 1'b1;
      end
    end
    rready <= 1'b0;
    if (!got) stall_out();
    @(posedge aclk);
  endtask : rd

  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].br);
      rd(rows[i].a, rows[i].q, rows[i].rr);
    end
    // Second reset in mid-run
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk32("count", 32'h0, {17'h0, tb_count});
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'h0000_7FFF, 2'h0);
    rd(8'h20, 32'h0, 2'h0);
    // Disabled pin low with interrupts enabled
    wr(8'h20, 32'h3, 2'h0);
    pull_a <= 2'h2;
    repeat (4) @(posedge aclk);
    chk1("irq", 1'b0, irq);
    chk32("override", 32'h0, {28'h0, override});
    rd(8'h14, 32'h2, 2'h0);
    rd(8'h1C, 32'h0, 2'h0);
    pull_a <= 2'h0;
    // Enabled pin A, sticky flag
    wr(8'h20, 32'h0, 2'h0);
    wr(8'h0C, 32'h5, 2'h0);
    pull_a <= 2'h1;
    repeat (3) @(posedge aclk);
    chk32("override", 32'h5, {28'h0, override});
    pull_a <= 2'h0;
    repeat (2) @(posedge aclk);
    chk1("irq", 1'b0, irq);
    rd(8'h1C, 32'h1, 2'h0);
    wr(8'h20, 32'h1, 2'h0);
    chk1("a_irq", 1'b1, a_irq);
    chk1("b_irq", 1'b0, b_irq);
    chk1("irq", 1'b1, irq);
    wr(8'h24, 32'h1, 2'h0);
    chk1("irq", 1'b0, irq);
    rd(8'h1C, 32'h0, 2'h0);
    // Pin B pulled by its second source
    wr(8'h10, 32'h2, 2'h0);
    wr(8'h20, 32'h3, 2'h0);
    pull_b <= 2'h2;
    repeat (3) @(posedge aclk);
    chk32("override", 32'h2, {28'h0, override});
    pull_b <= 2'h0;
    @(posedge aclk);
    chk1("b_irq", 1'b1, b_irq);
    chk1("a_irq", 1'b0, a_irq);
    rd(8'h1C, 32'h2, 2'h0);
    wr(8'h24, 32'h2, 2'h0);
    wr(8'h10, 32'h0, 2'h0);
    // Free pins as general purpose outputs
    wr(8'h18, 32'h3, 2'h0);
    wr(8'h14, 32'h1, 2'h0);
    chk1("a_oe", 1'b0, a_oe);
    chk1("b_oe", 1'b1, b_oe);
    chk1("b_out", 1'b0, b_out);
    rd(8'h14, 32'h1, 2'h0);
    chk1("irq", 1'b0, irq);
    wr(8'h0C, 32'h0, 2'h0);
    chk1("a_oe", 1'b1, a_oe);
    chk1("a_out", 1'b1, a_out);
    // Per-pin priority outputs
    wr(8'h28, 32'h0000_001D, 2'h0);
    chk32("prio_a", 32'h5, {29'h0, a_prio});
    chk32("prio_b", 32'h3, {29'h0, b_prio});
    // Up/down count turns at the period and at zero
    wr(8'h04, 32'h2, 2'h0);
    wr(8'h08, 32'h3, 2'h0);
    wait_dir(1'b1);
    chk1("dir_down", 1'b1, tb_dir);
    chk32("count_top", 32'h2, {17'h0, tb_count});
    wait_dir(1'b0);
    chk1("dir_up", 1'b0, tb_dir);
    chk32("count_bottom", 32'h0, {17'h0, tb_count});
    finish_test();
  end
endmodule : pwm_timebase_fault_inputs_bench
